// ### inc/asr_regs.svh
`ifndef ASR_REGS_SVH
`define ASR_REGS_SVH
// register byte offsets
`define ASR_OFF_STATUS  5'h00
`define ASR_OFF_DATA    5'h04
`define ASR_OFF_RATE    5'h08
`define ASR_OFF_CTRL_A  5'h0c
`define ASR_OFF_CTRL_B  5'h10
`define ASR_OFF_RXFINE  5'h14
`define ASR_OFF_TXFINE  5'h18
// reset values
`define ASR_STATUS_RST  8'hc0
`define ASR_BYTE_RST    8'h00
// uart_ctrl_a fields
`define ASR_A_R9        7
`define ASR_A_T9        6
`define ASR_A_NINE      4
`define ASR_A_WAKE      3
// uart_ctrl_b fields
`define ASR_B_TIE       7
`define ASR_B_TX_DONE_IRQ_ON      6
`define ASR_B_RIE       5
`define ASR_B_IDLE_IRQ_ON      4
`define ASR_B_TE        3
`define ASR_B_RE        2
`define ASR_B_MUTE      1
`define ASR_B_SBK       0
// rate_select fields
`define ASR_R_PR_HI     7
`define ASR_R_PR_LO     6
`define ASR_R_TX_HI     5
`define ASR_R_TX_LO     3
`define ASR_R_RX_HI     2
`define ASR_R_RX_LO     0
// base divider factors doubled (32x bit = 16 samples x 2)
`define ASR_PR1_X2      12'h002
`define ASR_PR3_X2      12'h006
`define ASR_PR4_X2      12'h008
`define ASR_PR13_X2     12'h01a
// oversampling timing
`define ASR_SUB_LAST    4'hf
`define ASR_SUB_S0      4'h7
`define ASR_SUB_S1      4'h8
`define ASR_SUB_S2      4'h9
`define ASR_LAST_BIT8   4'h9
`define ASR_LAST_BIT9   4'ha
`define ASR_IDLE_LIM8   8'ha0
`define ASR_IDLE_LIM9   8'hb0
`endif

// ### inc/asr_pkg.sv
package asr_pkg;
    // transmitter states
    typedef enum logic [1:0] {TX_IDLE = 2'b01, TX_SEND = 2'b10} asr_tx_e;
    // receiver states
    typedef enum logic [1:0] {RX_HUNT = 2'b01, RX_RECV = 2'b10} asr_rx_e;
endpackage

// ### hw/asr_top.sv
// Our own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "asr_regs.svh"
// Contract
// - empty flag sets on load, clears by sequence
// - no load while empty flag set
// - done flag sets at frame end
// - full flag on receive, clears off or sequence
// - idle flag once per full, not on wake
// - overrun keeps holding, shift overwritten
// - noise flag with full, no own interrupt
// - framing flag, clears by sequence or off
// - framing plus overrun sets only overrun
// - eight or nine data bits, ninth bits
// - wake method idle or address mark
// - transmit interrupt enables gate flags
// - receive and idle interrupt enables
// - tx_on enables transmitter, owns pin
// - tx_on toggle sends preamble after word
// - rx_on clear resets receive flags
// - mute set by software, cleared on wake
// - break while set, one after clear
// - data read holding, write tx holding
// - base code decodes to 1,3,4,13
// - tx power-of-two unless fine nonzero
// - rx power-of-two unless fine nonzero
// - conventional rate clk/(32*base*divisor)
// - fine rate clk/(16*fine)
// - address mark clears mute, sets full
module asr_top
    import asr_pkg::*;
#(
    parameter int DIV_W = 12
)(
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [4:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // serial pins
    input  wire logic        rx_in,
    output logic             tx_out,
    output logic             tx_serial_sel,
    // interrupt request
    output logic             irq
);

////////////////////////////////////////////////////////////////////////////////
// elaboration check: largest conventional divide is 26<<7
generate
    if (DIV_W < 12)
    begin : g_chk
        $error("asr_top: DIV_W must be at least 12");
    end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// state declarations
logic [7:0]       ctrl_b_r;      // enables, mute, break
logic             nine_r;        // nine data bits
logic             wake_r;        // wake method
logic             t9_r;          // ninth transmit bit
logic             r9_r;          // ninth received bit
logic [7:0]       rate_r;        // rate_select
logic [7:0]       rx_fine_r;     // fine rx divisor
logic [7:0]       tx_fine_r;     // fine tx divisor
logic [7:0]       tx_hold_r;     // tx_holding
logic [7:0]       rx_hold_r;     // rx_holding
logic             tx_empty_r;    // tx_empty_flag
logic             tx_done_r;     // tx_done_flag
logic             rx_full_r;     // rx_full_flag
logic             idle_r;        // idle-line flag
logic             ovr_r;         // overrun_flag
logic             noise_r;       // noise_flag
logic             fe_r;          // framing_error_flag
logic             sr_seen_r;     // status accessed, awaiting data access
logic             off_seen_r;    // tx_on cleared mid-frame
logic             pre_pend_r;    // preamble owed
logic             brk_pend_r;    // one break owed
logic             brk_sent_r;    // break started since set
logic             idle_arm_r;    // idle may set again
logic [DIV_W-1:0] tx_cnt_r;      // tx sample divider
logic [DIV_W-1:0] rx_cnt_r;      // rx sample divider
logic             tx_tick_r;     // tx sample tick
logic             rx_tick_r;     // rx sample tick
asr_tx_e          tx_st_r;       // transmitter state
logic [10:0]      tx_sh_r;       // tx frame shifter
logic [3:0]       tx_sub_r;      // tx sample in bit
logic [3:0]       tx_bit_r;      // tx bit index
asr_rx_e          rx_st_r;       // receiver state
logic [8:0]       rx_sh_r;       // rx shift register
logic [3:0]       rx_sub_r;      // rx sample in bit
logic [3:0]       rx_bit_r;      // rx bit index
logic [2:0]       rx_smp_r;      // three mid-bit samples
logic             rx_nz_r;       // noise seen this frame
logic [7:0]       idle_cnt_r;    // high-line sample count
logic [31:0]      prdata_r;
logic             pready_r;
logic             pslverr_r;
logic             tx_out_r;
logic             tx_sel_r;
logic             irq_r;

////////////////////////////////////////////////////////////////////////////////
// apb decode
logic        setup;             // setup phase
logic        acc;               // completing access
logic        hit;               // mapped address
logic [7:0]  rd_mux;            // read data
logic        wr_data;
logic        rd_data;
logic        wr_ctrl_b;
logic        seq_wr;            // status then data write
logic        seq_rd;            // status then data read
assign setup     = psel && !penable;
assign acc       = psel && penable && pready_r;
assign wr_data   = acc && pwrite && (paddr == `ASR_OFF_DATA);
assign rd_data   = acc && !pwrite && (paddr == `ASR_OFF_DATA);
assign wr_ctrl_b = acc && pwrite && (paddr == `ASR_OFF_CTRL_B);
assign seq_wr    = wr_data && sr_seen_r;
assign seq_rd    = rd_data && sr_seen_r;

// read mux, reserved bits read zero
always_comb
begin
    hit    = 1'b1;
    rd_mux = `ASR_BYTE_RST;
    case (paddr)
        `ASR_OFF_STATUS: rd_mux = {tx_empty_r, tx_done_r, rx_full_r, idle_r, ovr_r, noise_r, fe_r, 1'b0};
        `ASR_OFF_DATA:   rd_mux = rx_hold_r;
        `ASR_OFF_RATE:   rd_mux = rate_r;
        `ASR_OFF_CTRL_A: rd_mux = {r9_r, t9_r, 1'b0, nine_r, wake_r, 3'h0};
        `ASR_OFF_CTRL_B: rd_mux = ctrl_b_r;
        `ASR_OFF_RXFINE: rd_mux = rx_fine_r;
        `ASR_OFF_TXFINE: rd_mux = tx_fine_r;
        default:         hit = 1'b0; // unmapped: error, zero data
    endcase
end

// apb answer one cycle after setup
always_ff @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        pready_r  <= 1'b0;
        prdata_r  <= 32'h0000_0000;
        pslverr_r <= 1'b0;
    end
    else
    begin
        pready_r <= setup;
        if (setup)
        begin
            prdata_r  <= {24'h00_0000, rd_mux};
            pslverr_r <= !hit;
        end
    end
end

// clear sequence tracker: any status access arms it
always_ff @(posedge pclk or negedge presetn)
begin
    if (!presetn)
        sr_seen_r <= 1'b0;
    else if (acc && paddr == `ASR_OFF_STATUS)
        sr_seen_r <= 1'b1;
    else if (wr_data || rd_data)
        sr_seen_r <= 1'b0;
end

////////////////////////////////////////////////////////////////////////////////
// configuration registers
logic mute_wake;               // hardware wake-up clears mute
always_ff @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        ctrl_b_r  <= `ASR_BYTE_RST;
        rate_r    <= `ASR_BYTE_RST;
        rx_fine_r <= `ASR_BYTE_RST;
        tx_fine_r <= `ASR_BYTE_RST;
        nine_r    <= 1'b0;
        wake_r    <= 1'b0;
        t9_r      <= 1'b0;
    end
    else
    begin
        if (acc && pwrite && paddr == `ASR_OFF_RATE)
            rate_r <= pwdata[7:0];
        if (acc && pwrite && paddr == `ASR_OFF_RXFINE)
            rx_fine_r <= pwdata[7:0];
        if (acc && pwrite && paddr == `ASR_OFF_TXFINE)
            tx_fine_r <= pwdata[7:0];
        if (acc && pwrite && paddr == `ASR_OFF_CTRL_A)
        begin
            nine_r <= pwdata[`ASR_A_NINE];
            wake_r <= pwdata[`ASR_A_WAKE];
            t9_r   <= pwdata[`ASR_A_T9];
        end
        // software write is newer than a wake in the same cycle
        if (wr_ctrl_b)
            ctrl_b_r <= pwdata[7:0];
        else if (mute_wake)
            ctrl_b_r[`ASR_B_MUTE] <= 1'b0;
    end
end

////////////////////////////////////////////////////////////////////////////////
// rate generators: one tick per sample, sixteen samples per bit
function automatic logic [DIV_W-1:0] div_of(input logic [1:0] pc, input logic [2:0] n, input logic [7:0] fine);
    logic [11:0] px2;
    px2 = `ASR_PR1_X2;
    case (pc)
        2'h0:    px2 = `ASR_PR1_X2;
        2'h1:    px2 = `ASR_PR3_X2;
        2'h2:    px2 = `ASR_PR4_X2;
        default: px2 = `ASR_PR13_X2;
    endcase
    // fine value replaces the whole divider, base factor and power of two
    if (fine != 8'h00)
        div_of = DIV_W'(fine);
    else
        div_of = DIV_W'(px2 << n);
endfunction

logic [DIV_W-1:0] tx_div;
logic [DIV_W-1:0] rx_div;
assign tx_div = div_of(rate_r[`ASR_R_PR_HI:`ASR_R_PR_LO], rate_r[`ASR_R_TX_HI:`ASR_R_TX_LO], tx_fine_r);
assign rx_div = div_of(rate_r[`ASR_R_PR_HI:`ASR_R_PR_LO], rate_r[`ASR_R_RX_HI:`ASR_R_RX_LO], rx_fine_r);

// independent dividers; >= guards a divisor lowered mid-count
always_ff @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        tx_cnt_r  <= '0;
        rx_cnt_r  <= '0;
        tx_tick_r <= 1'b0;
        rx_tick_r <= 1'b0;
    end
    else
    begin
        tx_tick_r <= (tx_cnt_r >= tx_div - DIV_W'(1));
        rx_tick_r <= (rx_cnt_r >= rx_div - DIV_W'(1));
        tx_cnt_r  <= (tx_cnt_r >= tx_div - DIV_W'(1)) ? '0 : tx_cnt_r + DIV_W'(1);
        rx_cnt_r  <= (rx_cnt_r >= rx_div - DIV_W'(1)) ? '0 : rx_cnt_r + DIV_W'(1);
    end
end

////////////////////////////////////////////////////////////////////////////////
// transmitter
logic       tx_on;
logic       break_send;
logic       tx_idle;
logic       ld_brk;            // start break frame
logic       ld_pre;            // start preamble frame
logic       ld_dat;            // move holding into shifter
logic       tx_fin;            // frame finished
logic [3:0] tx_last;
assign tx_on   = ctrl_b_r[`ASR_B_TE];
assign break_send     = ctrl_b_r[`ASR_B_SBK];
assign tx_idle = (tx_st_r == TX_IDLE);
assign tx_last = nine_r ? `ASR_LAST_BIT9 : `ASR_LAST_BIT8;
assign ld_brk  = tx_idle && tx_on && (break_send || brk_pend_r);
assign ld_pre  = tx_idle && tx_on && !ld_brk && pre_pend_r;
assign ld_dat  = tx_idle && tx_on && !ld_brk && !ld_pre && !tx_empty_r;
assign tx_fin  = !tx_idle && tx_tick_r && tx_sub_r == `ASR_SUB_LAST && tx_bit_r == tx_last;

// frame shifter; line idles high
always_ff @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        tx_st_r  <= TX_IDLE;
        tx_sh_r  <= 11'h7ff;
        tx_sub_r <= 4'h0;
        tx_bit_r <= 4'h0;
        tx_out_r <= 1'b1;
    end
    else if (ld_brk || ld_pre || ld_dat)
    begin
        tx_st_r  <= TX_SEND;
        tx_sub_r <= 4'h0;
        tx_bit_r <= 4'h0;
        // break: all zeros; preamble: all ones
        if (ld_brk)
            tx_sh_r <= 11'h000;
        else if (ld_pre)
            tx_sh_r <= 11'h7ff;
        else
            tx_sh_r <= {1'b1, nine_r ? t9_r : 1'b1, tx_hold_r, 1'b0};
        tx_out_r <= ld_pre;
    end
    else if (!tx_idle && tx_tick_r)
    begin
        tx_sub_r <= tx_sub_r + 4'h1;
        if (tx_sub_r == `ASR_SUB_LAST)
        begin
            if (tx_fin)
            begin
                tx_st_r  <= TX_IDLE;
                tx_out_r <= 1'b1;
            end
            else
            begin
                tx_sh_r  <= {1'b1, tx_sh_r[10:1]};
                tx_out_r <= tx_sh_r[1];
                tx_bit_r <= tx_bit_r + 4'h1;
            end
        end
    end
end

// transmit flags, set wins over clear
always_ff @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        tx_empty_r <= 1'b1;
        tx_done_r  <= 1'b1;
        tx_hold_r  <= `ASR_BYTE_RST;
    end
    else
    begin
        if (wr_data)
            tx_hold_r <= pwdata[7:0];
        if (ld_dat)
            tx_empty_r <= 1'b1;
        else if (seq_wr)
            tx_empty_r <= 1'b0;
        if (tx_fin)
            tx_done_r <= 1'b1;
        else if (seq_wr)
            tx_done_r <= 1'b0;
    end
end

// preamble and break bookkeeping
always_ff @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        off_seen_r <= 1'b0;
        pre_pend_r <= 1'b0;
        brk_pend_r <= 1'b0;
        brk_sent_r <= 1'b0;
    end
    else
    begin
        // tx_on 0 then 1 while a frame runs owes a preamble
        if (wr_ctrl_b && !pwdata[`ASR_B_TE] && !tx_idle)
            off_seen_r <= 1'b1;
        else if ((wr_ctrl_b && pwdata[`ASR_B_TE]) || tx_fin)
            off_seen_r <= 1'b0;
        if (wr_ctrl_b && pwdata[`ASR_B_TE] && off_seen_r)
            pre_pend_r <= 1'b1;
        else if (ld_pre)
            pre_pend_r <= 1'b0;
        // set then cleared before any break went out owes one
        if (wr_ctrl_b && break_send && !pwdata[`ASR_B_SBK] && !brk_sent_r)
            brk_pend_r <= 1'b1;
        else if (ld_brk)
            brk_pend_r <= 1'b0;
        if (ld_brk)
            brk_sent_r <= 1'b1;
        else if (wr_ctrl_b && !break_send && pwdata[`ASR_B_SBK])
            brk_sent_r <= 1'b0;
    end
end

////////////////////////////////////////////////////////////////////////////////
// receiver
logic       rx_on;
logic       muted;
logic       maj;               // majority of three samples
logic       rx_end;            // stop bit evaluated
logic       rx_take;           // word reaches the flags
logic       idle_ev;           // idle frame seen
logic [3:0] rx_last;
logic [7:0] idle_lim;
assign rx_on    = ctrl_b_r[`ASR_B_RE];
assign muted    = ctrl_b_r[`ASR_B_MUTE];
assign rx_last  = nine_r ? `ASR_LAST_BIT9 : `ASR_LAST_BIT8;
assign idle_lim = nine_r ? `ASR_IDLE_LIM9 : `ASR_IDLE_LIM8;
assign maj      = (rx_smp_r[0] & rx_smp_r[1]) | (rx_smp_r[0] & rx_smp_r[2]) | (rx_smp_r[1] & rx_smp_r[2]);
assign rx_end   = rx_st_r == RX_RECV && rx_tick_r && rx_sub_r == `ASR_SUB_LAST && rx_bit_r == rx_last;
// address mark: msb of the word sits in rx_sh_r[8] for both lengths
// gated by rx_on so a frame ending as the receiver is switched off sets nothing
assign rx_take  = rx_on && rx_end && (!muted || (wake_r && rx_sh_r[8]));
assign idle_ev  = rx_on && rx_st_r == RX_HUNT && rx_tick_r && rx_in && idle_cnt_r == idle_lim - 8'h01;
assign mute_wake = muted && ((rx_end && wake_r && rx_sh_r[8]) || (idle_ev && !wake_r));

// start hunt, mid-bit sampling, shift lsb first
always_ff @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        rx_st_r  <= RX_HUNT;
        rx_sh_r  <= 9'h000;
        rx_sub_r <= 4'h0;
        rx_bit_r <= 4'h0;
        rx_smp_r <= 3'h7;
        rx_nz_r  <= 1'b0;
    end
    else if (!rx_on)
        rx_st_r <= RX_HUNT;
    else if (rx_tick_r)
    begin
        if (rx_st_r == RX_HUNT)
        begin
            if (!rx_in)
            begin
                rx_st_r  <= RX_RECV;
                rx_sub_r <= 4'h0;
                rx_bit_r <= 4'h0;
                rx_nz_r  <= 1'b0;
            end
        end
        else
        begin
            rx_sub_r <= rx_sub_r + 4'h1;
            if (rx_sub_r == `ASR_SUB_S0)
                rx_smp_r[0] <= rx_in;
            if (rx_sub_r == `ASR_SUB_S1)
                rx_smp_r[1] <= rx_in;
            if (rx_sub_r == `ASR_SUB_S2)
                rx_smp_r[2] <= rx_in;
            if (rx_sub_r == `ASR_SUB_LAST)
            begin
                // disagreeing samples mark noise
                if (rx_smp_r != 3'h0 && rx_smp_r != 3'h7)
                    rx_nz_r <= 1'b1;
                rx_bit_r <= rx_bit_r + 4'h1;
                if (rx_bit_r == 4'h0 && maj)
                    rx_st_r <= RX_HUNT; // false start
                else if (rx_end)
                    rx_st_r <= RX_HUNT;
                else if (rx_bit_r != 4'h0)
                    rx_sh_r <= {maj, rx_sh_r[8:1]};
            end
        end
    end
end

// idle counter saturates so one idle stretch fires once
always_ff @(posedge pclk or negedge presetn)
begin
    if (!presetn)
        idle_cnt_r <= 8'h00;
    else if (!rx_on || rx_st_r != RX_HUNT || !rx_in)
        idle_cnt_r <= 8'h00;
    else if (rx_tick_r && idle_cnt_r != idle_lim)
        idle_cnt_r <= idle_cnt_r + 8'h01;
end

// receive flags: rx_on low clears, set beats sequence clear
always_ff @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        rx_full_r  <= 1'b0;
        idle_r     <= 1'b0;
        ovr_r      <= 1'b0;
        noise_r    <= 1'b0;
        fe_r       <= 1'b0;
        rx_hold_r  <= `ASR_BYTE_RST;
        r9_r       <= 1'b0;
        idle_arm_r <= 1'b1;
    end
    else if (!rx_on)
    begin
        rx_full_r <= 1'b0;
        idle_r    <= 1'b0;
        ovr_r     <= 1'b0;
        noise_r   <= 1'b0;
        fe_r      <= 1'b0;
    end
    else
    begin
        if (seq_rd)
        begin
            rx_full_r <= 1'b0;
            idle_r    <= 1'b0;
            ovr_r     <= 1'b0;
            noise_r   <= 1'b0;
            fe_r      <= 1'b0;
        end
        if (rx_take && rx_full_r)
            ovr_r <= 1'b1; // holding kept, only overrun
        else if (rx_take)
        begin
            rx_full_r  <= 1'b1;
            idle_arm_r <= 1'b1;
            rx_hold_r  <= nine_r ? rx_sh_r[7:0] : rx_sh_r[8:1];
            r9_r       <= nine_r & rx_sh_r[8];
            noise_r    <= rx_nz_r;
            fe_r       <= !maj;
        end
        // idle that wakes from mute sets nothing
        if (idle_ev && !muted && idle_arm_r)
        begin
            idle_r     <= 1'b1;
            idle_arm_r <= 1'b0;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// outputs: pin handover, interrupt level
logic irq_nxt;
always_comb
begin
    irq_nxt = (ctrl_b_r[`ASR_B_TIE] && tx_empty_r) || (ctrl_b_r[`ASR_B_TX_DONE_IRQ_ON] && tx_done_r)
           || (ctrl_b_r[`ASR_B_RIE] && (ovr_r || rx_full_r))
           || (ctrl_b_r[`ASR_B_IDLE_IRQ_ON] && idle_r);
end

always_ff @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        irq_r    <= 1'b0;
        tx_sel_r <= 1'b0;
    end
    else
    begin
        irq_r    <= irq_nxt;
        tx_sel_r <= tx_on;
    end
end

assign prdata        = prdata_r;
assign pready        = pready_r;
assign pslverr       = pslverr_r;
assign tx_out        = tx_out_r;
assign tx_serial_sel = tx_sel_r;
assign irq           = irq_r;

////////////////////////////////////////////////////////////////////////////////
// assertions
default clocking cb @(posedge pclk); endclocking
default disable iff (!presetn);

a_empty_on_load:  assert property (ld_dat |=> tx_empty_r && !tx_idle)
    else $error("empty flag not set on load");
// shifter must stay idle while holding is empty and nothing else is owed
a_no_early_load:  assert property (tx_empty_r && tx_idle && !ld_brk && !ld_pre |=> tx_idle)
    else $error("load while holding empty");
a_done_at_end:    assert property (tx_fin |=> tx_done_r && tx_out_r)
    else $error("done flag missing");
a_rx_off_flags:   assert property (!rx_on |=> !rx_full_r && !ovr_r && !idle_r && !fe_r)
    else $error("rx off kept flags");
a_overrun_keep:   assert property (rx_take && rx_full_r |=> ovr_r && $stable(rx_hold_r))
    else $error("overrun lost hold");
a_irq_follow:     assert property (##1 irq_r == $past(irq_nxt))
    else $error("irq not tracking flags");
a_tx_idle_high:   assert property (tx_idle && !$past(ld_brk || ld_pre || ld_dat) |-> tx_out_r)
    else $error("line low idle");
a_read_holding:   assert property (
    setup && !pwrite && paddr == `ASR_OFF_DATA |=> prdata_r[7:0] == $past(rx_hold_r))
    else $error("data read wrong");

endmodule
`default_nettype wire

// ### sim/asr_node.sv
`timescale 1ns/100ps
`default_nettype none
module asr_node (
    // clock
    input  wire logic       pclk,
    // serial lines
    input  wire logic       tx_out,
    output logic            rx_line,
    // last byte heard
    output logic [7:0]      got
);
    // clocks per bit, set by the bench per rate
    int bitw = 32;
    // line idles high between frames
    initial
    begin
        rx_line = 1'b1;
        got = 8'h00;
    end
    // listener: start edge, then mid-bit samples, lsb first
    always
    begin
        @(negedge tx_out);
        repeat (bitw + bitw / 2) @(posedge pclk);
        for (int i = 0; i < 8; i++)
        begin
            got[i] = tx_out;
            repeat (bitw) @(posedge pclk);
        end
    end
    // talker: start, eight data lsb first, stop
    task automatic send(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++)
        begin
            rx_line <= f[i];
            repeat (bitw) @(posedge pclk);
        end
    endtask
endmodule
`default_nettype wire

// ### sim/tb_asr_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "asr_regs.svh"
module tb_asr_top;
    // apb side
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [4:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    // serial pins and interrupt
    logic        rx_in;
    logic        tx_out;
    logic        tx_serial_sel;
    logic        irq;
    logic [7:0]  node_got;
    // bookkeeping
    logic        perr;
    int          num_errors = 0;
    int          checked = 0;
    ////////////////////////////////////////
    asr_top asr_top_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rx_in(rx_in), .tx_out(tx_out),
        .tx_serial_sel(tx_serial_sel), .irq(irq)
    );
    asr_node asr_node_inst (
        .pclk(pclk), .tx_out(tx_out), .rx_line(rx_in), .got(node_got)
    );
    // 25 MHz clock
    initial
    begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    ////////////////////////////////////////
    // compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one apb transfer; idle edge after so strobes never change twice at once
    task automatic apb(input logic w, input logic [4:0] a, input logic [31:0] d, output logic [31:0] r);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        logic [31:0] r;
        apb(1'b1, a, {24'h0, d}, r);
    endtask
    task automatic rd(input logic [4:0] a, input logic [31:0] exp);
        logic [31:0] r;
        apb(1'b0, a, 32'h0, r);
        check(r, exp);
    endtask
    // send one byte at a given rate and catch it at the far end
    task automatic tx_case(input logic [7:0] rate, input logic [7:0] fine, input int bw, input logic [7:0] d);
        wr(`ASR_OFF_RATE, rate);
        wr(`ASR_OFF_TXFINE, fine);
        asr_node_inst.bitw = bw;
        rd(`ASR_OFF_STATUS, 32'hc0);
        wr(`ASR_OFF_DATA, d);
        rd(`ASR_OFF_STATUS, 32'h80);
        check(irq, 1'b0);
        repeat (11 * bw) @(posedge pclk);
        check(node_got, d);
        rd(`ASR_OFF_STATUS, 32'hc0);
        check(irq, 1'b1);
    endtask
    // verdict
    task automatic close_out();
        if (num_errors == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // a hang ends here; tests need about 6000 cycles
    initial
    begin
        repeat (20000) @(posedge pclk);
        num_errors++;
        close_out();
    end
    ////////////////////////////////////////
    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 5'h00;
        pwdata = 32'h0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(`ASR_OFF_STATUS, 32'hc0);
        rd(`ASR_OFF_CTRL_B, 32'h0);
        rd(5'h1c, 32'h0);
        check(perr, 1'b1);
        wr(`ASR_OFF_CTRL_B, 8'h48);
        rd(`ASR_OFF_CTRL_B, 32'h48);
        check(tx_serial_sel, 1'b1);
        check(irq, 1'b1);
        // plain, coarse with divisor, fine overriding the code
        tx_case(8'h00, 8'h00, 32, 8'ha5);
        tx_case(8'h88, 8'h00, 256, 8'h5a);
        tx_case(8'h38, 8'h01, 16, 8'h96);
        // receive, then an overrun
        asr_node_inst.bitw = 32;
        wr(`ASR_OFF_CTRL_B, 8'h2c);
        asr_node_inst.send(8'h3c);
        repeat (40) @(posedge pclk);
        check(irq, 1'b1);
        rd(`ASR_OFF_STATUS, 32'he0);
        rd(`ASR_OFF_DATA, 32'h3c);
        rd(`ASR_OFF_STATUS, 32'hc0);
        asr_node_inst.send(8'h11);
        asr_node_inst.send(8'h22);
        repeat (40) @(posedge pclk);
        rd(`ASR_OFF_STATUS, 32'he8);
        rd(`ASR_OFF_DATA, 32'h11);
        // quiet line raises idle once
        repeat (400) @(posedge pclk);
        rd(`ASR_OFF_STATUS, 32'hd0);
        // address-mark wake: msb 0 stays muted, msb 1 wakes and is received
        wr(`ASR_OFF_CTRL_A, 8'h08);
        wr(`ASR_OFF_CTRL_B, 8'h2e);
        asr_node_inst.send(8'h11);
        repeat (40) @(posedge pclk);
        rd(`ASR_OFF_STATUS, 32'hd0);
        rd(`ASR_OFF_CTRL_B, 32'h2e);
        asr_node_inst.send(8'h91);
        repeat (40) @(posedge pclk);
        rd(`ASR_OFF_STATUS, 32'hf0);
        rd(`ASR_OFF_DATA, 32'h91);
        rd(`ASR_OFF_CTRL_B, 32'h2c);
        wr(`ASR_OFF_CTRL_B, 8'h08);
        rd(`ASR_OFF_STATUS, 32'hc0);
        close_out();
    end
endmodule
`default_nettype wire
